// ---- design/conv_ctrl_pkg.sv ----
/*
 Constants shared by the converter control block and its clock divider.
 Assumes a 32-bit APB register bus and a 10-bit successive approximation
 converter core.
*/
package conv_ctrl_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CLEAR = 8'h08;
  localparam logic [7:0] ADDR_ENABLE = 8'h0C;
  localparam logic [7:0] ADDR_RESULT = 8'h10;

  // ----------------------------------------------------------------
  // Field layout of converter_control_third
  // ----------------------------------------------------------------
  localparam int CLKSEL_LSB = 0;
  localparam int CLKSEL_W = 3;
  localparam int JUSTIFY_BIT = 3;
  localparam int GO_BIT = 4;
  localparam int DONE_BIT = 0;

  // ----------------------------------------------------------------
  // Reset values and sizes
  // ----------------------------------------------------------------
  localparam logic [2:0] CLKSEL_RESET = 3'h0;
  localparam logic JUSTIFY_RIGHT = 1'b1;
  localparam logic JUSTIFY_RESET = 1'b0;
  localparam int RESULT_BITS = 10;
  localparam int RESULT_REG_W = 16;
  localparam int DIV_CNT_W = 6;

  // Conversion clock select codes with the RC clock on x11
  localparam logic [1:0] CLKSEL_RC_LOW = 2'h3;

  typedef enum logic [1:0] {
    sar_idle,
    sar_sample,
    sar_convert,
    sar_finish
  } sar_state_e;

  typedef enum logic [1:0] {
    core_run,
    core_asleep,
    core_next_instr,
    core_dispatch
  } wake_state_e;

endpackage

// ---- design/conv_clock_gen.sv ----
/*
 Conversion bit period tick generator.
 Assumes rc_osc comes from the dedicated RC oscillator, asynchronous to
 ref_clk and well below half its rate.
*/
`timescale 1ns/1ps
`default_nettype none

module conv_clock_gen
  import conv_ctrl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [2:0] conv_clock_select,
  input wire logic rc_osc,
  output logic conv_bit_period
);

  // ----------------------------------------------------------------
  // Divider and RC clock sampling
  // ----------------------------------------------------------------
  logic [DIV_CNT_W-1:0] div_cnt;
  logic rc_meta;
  logic rc_sync;
  logic rc_last;

  // Exponent 1..6 from the scrambled select code
  wire [2:0] div_exp = {conv_clock_select[1:0], conv_clock_select[2]}
                       + 3'h1;
  wire [DIV_CNT_W-1:0] div_mask = DIV_CNT_W'((7'h01 << div_exp) - 7'h01);
  wire use_rc = (conv_clock_select[1:0] == CLKSEL_RC_LOW);
  wire div_tick = ((div_cnt & div_mask) == div_mask);
  wire rc_tick = rc_sync & ~rc_last;
  wire next_tick = use_rc ? rc_tick : div_tick;

  // Free running divider counter
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      div_cnt <= '0;
    else
      div_cnt <= div_cnt + 1'b1;
  end

  // Two flip-flop synchroniser and edge detect for the RC clock
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rc_meta <= 1'b0;
      rc_sync <= 1'b0;
      rc_last <= 1'b0;
      conv_bit_period <= 1'b0;
    end
    else
    begin
      rc_meta <= rc_osc;
      rc_sync <= rc_meta;
      rc_last <= rc_sync;
      conv_bit_period <= next_tick;
    end
  end

endmodule

`default_nettype wire

// ---- design/conv_ctrl.sv ----
/*
 Converter control: APB registers, conversion clock select, successive
 approximation sequencer, done flag with interrupt, wake from Sleep and
 result justification.
 Assumes the analog comparator output arrives asynchronously and the core
 reports Sleep and its global interrupt enable on the ref_clk domain.
*/
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module conv_ctrl
  import conv_ctrl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rc_osc,
  input wire logic comp_out,
  output logic [RESULT_BITS-1:0] dac_code,
  output logic sample_hold,
  input wire logic sleep_mode,
  input wire logic global_irq_enable,
  output logic conv_irq,
  output logic wake_req,
  output logic exec_next_instr,
  output logic vector_isr,
  output logic resume_inline
);

  // ----------------------------------------------------------------
  // Register bus decode
  // ----------------------------------------------------------------
  logic [2:0] conv_clock_select;
  logic result_justify_select;
  logic conv_done_flag;
  logic conv_irq_enable;
  logic [RESULT_REG_W-1:0] result;
  sar_state_e sar_state;

  wire setup = psel & ~penable;
  wire wr_access = psel & penable & pwrite & pready;
  wire hit_control = (paddr == ADDR_CONTROL);
  wire hit_status = (paddr == ADDR_STATUS);
  wire hit_clear = (paddr == ADDR_CLEAR);
  wire hit_enable = (paddr == ADDR_ENABLE);
  wire hit_result = (paddr == ADDR_RESULT);
  wire mapped = hit_control | hit_status | hit_clear | hit_enable |
                hit_result;
  wire wr_control = wr_access & hit_control;
  wire wr_clear = wr_access & hit_clear;
  wire wr_enable = wr_access & hit_enable;
  wire busy = (sar_state != sar_idle);
  wire start_req = wr_control & pwdata[GO_BIT] & ~busy;

  // Read mux, write-only and unmapped words read as zero
  logic [31:0] rd_word;
  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (hit_control)
    begin
      rd_word[CLKSEL_LSB +: CLKSEL_W] = conv_clock_select;
      rd_word[JUSTIFY_BIT] = result_justify_select;
      rd_word[GO_BIT] = busy;
    end
    else if (hit_status)
      rd_word[DONE_BIT] = conv_done_flag;
    else if (hit_enable)
      rd_word[DONE_BIT] = conv_irq_enable;
    else if (hit_result)
      rd_word[RESULT_REG_W-1:0] = result;
  end

  // Zero wait answer: pready in the first access cycle
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      if (setup)
        prdata <= pwrite ? 32'h0000_0000 : rd_word;
    end
  end

  // Control and enable registers, control ignored while a conversion runs, enable always written
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      conv_clock_select <= CLKSEL_RESET;
      result_justify_select <= JUSTIFY_RESET;
      conv_irq_enable <= 1'b0;
    end
    else
    begin
      if (wr_control & ~busy)
      begin
        conv_clock_select <= pwdata[CLKSEL_LSB +: CLKSEL_W];
        result_justify_select <= pwdata[JUSTIFY_BIT];
      end
      if (wr_enable)
        conv_irq_enable <= pwdata[DONE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Conversion clock and comparator input
  // ----------------------------------------------------------------
  logic conv_bit_period;
  logic comp_meta;
  logic comp_sync;

  conv_clock_gen clock_gen (
    .ref_clk(ref_clk),
    .rst(rst),
    .conv_clock_select(conv_clock_select),
    .rc_osc(rc_osc),
    .conv_bit_period(conv_bit_period)
  );

  // Comparator output synchroniser
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      comp_meta <= 1'b0;
      comp_sync <= 1'b0;
    end
    else
    begin
      comp_meta <= comp_out;
      comp_sync <= comp_meta;
    end
  end

  // ----------------------------------------------------------------
  // Successive approximation sequencer
  // ----------------------------------------------------------------
  logic [3:0] bit_idx;
  logic conv_end;
  sar_state_e next_state;

  // Trial bit and kept code for the current step
  wire [RESULT_BITS-1:0] trial = RESULT_BITS'(1) << bit_idx;
  wire [RESULT_BITS-1:0] kept = comp_sync ? dac_code : (dac_code & ~trial);
  wire [RESULT_BITS-1:0] step_code = (bit_idx == 4'h0) ? kept :
                                     (kept | (trial >> 1));

  // Next state of the sequencer
  always_comb
  begin
    next_state = sar_state;
    case (sar_state)
      sar_idle:
        if (start_req)
          next_state = sar_sample;
      sar_sample:
        if (conv_bit_period)
          next_state = sar_convert;
      sar_convert:
        if (conv_bit_period && bit_idx == 4'h0)
          next_state = sar_finish;
      default:
        next_state = sar_idle;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      sar_state <= sar_idle;
      bit_idx <= 4'h0;
      dac_code <= '0;
      sample_hold <= 1'b0;
      conv_end <= 1'b0;
    end
    else
    begin
      sar_state <= next_state;
      conv_end <= (sar_state == sar_finish);
      sample_hold <= (next_state == sar_sample);
      if (sar_state == sar_sample && conv_bit_period)
      begin
        bit_idx <= 4'(RESULT_BITS - 1);
        dac_code <= RESULT_BITS'(1) << (RESULT_BITS - 1);
      end
      else if (sar_state == sar_convert && conv_bit_period)
      begin
        dac_code <= step_code;
        if (bit_idx != 4'h0)
          bit_idx <= bit_idx - 4'h1;
      end
    end
  end

  // Result formatting into the 16-bit pair
  wire [RESULT_REG_W-1:0] right_fmt = {6'h00, dac_code};
  wire [RESULT_REG_W-1:0] left_fmt = {dac_code, 6'h00};
  wire [RESULT_REG_W-1:0] next_result =
    (result_justify_select == JUSTIFY_RIGHT) ? right_fmt : left_fmt;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      result <= '0;
    else if (sar_state == sar_finish)
      result <= next_result;
  end

  // ----------------------------------------------------------------
  // Done flag, interrupt and wake
  // ----------------------------------------------------------------
  // Set wins over a clear in the same cycle
  wire clr_done = wr_clear & pwdata[DONE_BIT];
  wire next_done = conv_end | (conv_done_flag & ~clr_done);
  wire irq_cond = next_done & conv_irq_enable;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      conv_done_flag <= 1'b0;
      conv_irq <= 1'b0;
      wake_req <= 1'b0;
    end
    else
    begin
      conv_done_flag <= next_done;
      conv_irq <= irq_cond;
      wake_req <= irq_cond & sleep_mode;
    end
  end

  // ----------------------------------------------------------------
  // Resume sequence after wake from Sleep
  // ----------------------------------------------------------------
  wake_state_e wake_state;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      wake_state <= core_run;
      exec_next_instr <= 1'b0;
      vector_isr <= 1'b0;
      resume_inline <= 1'b0;
    end
    else
    begin
      exec_next_instr <= 1'b0;
      vector_isr <= 1'b0;
      resume_inline <= 1'b0;
      case (wake_state)
        core_run:
          if (sleep_mode)
            wake_state <= core_asleep;
        core_asleep:
          if (wake_req)
          begin
            wake_state <= core_next_instr;
            exec_next_instr <= 1'b1;
          end
          else if (!sleep_mode)
            wake_state <= core_run;
        core_next_instr:
          begin
            wake_state <= core_dispatch;
            vector_isr <= global_irq_enable;
            resume_inline <= ~global_irq_enable;
          end
        default:
          wake_state <= sleep_mode ? core_dispatch : core_run;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence wake_seen;
    wake_state == core_asleep && wake_req;
  endsequence

  sequence next_then_dispatch;
    ##1 exec_next_instr ##1 (vector_isr || resume_inline);
  endsequence

  done_sets_a: assert property (@(posedge ref_clk) disable iff (rst)
    conv_end |=> conv_done_flag)
    else $error("done flag missed a conversion end");

  done_sticky_a: assert property (@(posedge ref_clk) disable iff (rst)
    conv_done_flag && !clr_done |=> conv_done_flag)
    else $error("done flag dropped without a clear");

  irq_level_a: assert property (@(posedge ref_clk) disable iff (rst)
    conv_irq == (conv_done_flag && $past(conv_irq_enable)))
    else $error("interrupt not tied to flag and enable");

  wake_sleep_a: assert property (@(posedge ref_clk) disable iff (rst)
    wake_req |-> conv_irq && $past(sleep_mode))
    else $error("wake without interrupt in sleep");

  next_first_a: assert property (@(posedge ref_clk) disable iff (rst)
    wake_seen |-> next_then_dispatch)
    else $error("wake not followed by next instruction then dispatch");

  vector_gie_a: assert property (@(posedge ref_clk) disable iff (rst)
    exec_next_instr |=> vector_isr == $past(global_irq_enable) &&
      resume_inline == !$past(global_irq_enable))
    else $error("dispatch ignores global interrupt enable");

  result_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(conv_end) |-> (result_justify_select ?
      result[15:10] == 6'h00 : result[5:0] == 6'h00))
    else $error("unused result bits not zero");

  justify_a: assert property (@(posedge ref_clk) disable iff (rst)
    sar_state == sar_finish |=> result == ($past(result_justify_select) ?
      {6'h00, $past(dac_code)} : {$past(dac_code), 6'h00}))
    else $error("result placed in wrong format");

  // Cycles spent in the sample phase waiting for a bit period tick
  localparam int SAMPLE_LIMIT = 2000;
  logic [10:0] sample_cnt;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      sample_cnt <= 11'h000;
    else
      sample_cnt <= (sar_state == sar_sample) ? sample_cnt + 11'h001 : 11'h000;
  end

  conv_len_a: assert property (@(posedge ref_clk) disable iff (rst)
    sample_cnt < SAMPLE_LIMIT)
    else $error("conversion clock tick never came");

endmodule

`default_nettype wire

// ---- verification/core_side_model.sv ----
/*
 Model of the processor core and the analog comparator.
 Assumes the bench gives the input level and the sleep command.
*/
`timescale 1ns/1ps
`default_nettype none

module core_side_model
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sleep_cmd,
  input wire logic gie_cmd,
  input wire logic exec_next_instr,
  input wire logic [9:0] vin,
  input wire logic [9:0] dac_code,
  output logic sleep_mode,
  output logic global_irq_enable,
  output logic comp_out
);
  // Comparator output follows vin against the present dac_code
  assign comp_out = (vin >= dac_code);
  assign global_irq_enable = gie_cmd;

  // Core sleeps on command and leaves sleep once woken
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      sleep_mode <= 1'b0;
    else if (sleep_cmd)
      sleep_mode <= 1'b1;
    else if (exec_next_instr)
      sleep_mode <= 1'b0;
  end
endmodule

`default_nettype wire

// ---- verification/adc_completion_irq_clock_format_tb.sv ----
/*
 Self-checking bench for the converter control block.
 Assumes the package constants and the core_side_model partner.
*/
`timescale 1ns/1ps
`default_nettype none

module adc_completion_irq_clock_format_tb;
  import conv_ctrl_pkg::*;
  logic ref_clk = 0, rst = 1, rc_osc = 0;
  logic psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic pready, pslverr, comp_out, sample_hold;
  logic sleep_mode, global_irq_enable, conv_irq, wake_req;
  logic exec_next_instr, vector_isr, resume_inline;
  logic sleep_cmd = 0, gie_cmd = 0;
  logic [9:0] vin = 0, dac_code;
  int err_count = 0, samples_checked = 0, cyc_cnt = 0;

  // ----------------------------------------------------------------
  // Clocks, reset, instances
  // ----------------------------------------------------------------
  always #25 ref_clk = ~ref_clk;
  always #850 rc_osc = ~rc_osc;
  always @(posedge ref_clk) cyc_cnt <= cyc_cnt + 1;

  conv_ctrl u_dut (.ref_clk(ref_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rc_osc(rc_osc),
    .comp_out(comp_out), .dac_code(dac_code), .sample_hold(sample_hold),
    .sleep_mode(sleep_mode), .global_irq_enable(global_irq_enable),
    .conv_irq(conv_irq), .wake_req(wake_req),
    .exec_next_instr(exec_next_instr), .vector_isr(vector_isr),
    .resume_inline(resume_inline));

  core_side_model u_core (.ref_clk(ref_clk), .rst(rst),
    .sleep_cmd(sleep_cmd), .gie_cmd(gie_cmd),
    .exec_next_instr(exec_next_instr), .vin(vin), .dac_code(dac_code),
    .sleep_mode(sleep_mode), .global_irq_enable(global_irq_enable),
    .comp_out(comp_out));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    if (err_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
      check(32'h0, 32'h1);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic e;
    apb(1'b0, a, 32'h0, rd, e);
    check(rd, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic e;
    apb(1'b1, a, d, rd, e);
  endtask

  function automatic logic [31:0] ctl(logic [2:0] s, logic rj, logic go);
    return {27'h0, go, rj, s};
  endfunction

  function automatic logic [31:0] res(logic [9:0] v, logic rj);
    return rj ? {22'h0, v} : {16'h0, v, 6'h00};
  endfunction

  // Poll the status until the done flag shows, return cycles taken
  task automatic wait_done(input int t0, output int cyc);
    logic [31:0] rd;
    logic e;
    rd = 32'h0;
    for (int i = 0; i < 300 && rd[DONE_BIT] !== 1'b1; i++)
      apb(1'b0, ADDR_STATUS, 32'h0, rd, e);
    check(rd, 32'h1);
    cyc = cyc_cnt - t0;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    logic [31:0] rd;
    logic e;
    logic [7:0] regs [4] = '{ADDR_CONTROL, ADDR_STATUS, ADDR_ENABLE,
                             ADDR_RESULT};
    foreach (regs[i])
      rd_chk(regs[i], 32'h0);
    apb(1'b1, 8'h14, 32'hFFFFFFFF, rd, e);
    check(e, 1'b1);
    apb(1'b0, 8'h14, 32'h0, rd, e);
    check(rd, 32'h0);
    check(e, 1'b1);
    rd_chk(ADDR_CONTROL, 32'h0);
  endtask

  task automatic t_irq_busy;
    int c;
    vin <= 10'h2AA;
    wr(ADDR_CONTROL, ctl(3'h5, 1'b1, 1'b1));
    c = cyc_cnt;
    #1 check(sample_hold, 1'b1);
    rd_chk(ADDR_CONTROL, ctl(3'h5, 1'b1, 1'b1));
    wr(ADDR_CONTROL, ctl(3'h0, 1'b0, 1'b1));
    wait_done(c, c);
    check(conv_irq, 1'b0);
    rd_chk(ADDR_RESULT, res(10'h2AA, 1'b1));
    rd_chk(ADDR_STATUS, 32'h1);
    wr(ADDR_ENABLE, 32'h1);
    @(posedge ref_clk);
    #1 check({conv_irq, wake_req}, 2'b10);
    wr(ADDR_ENABLE, 32'h0);
    @(posedge ref_clk);
    #1 check(conv_irq, 1'b0);
    wr(ADDR_ENABLE, 32'h1);
    wr(ADDR_CLEAR, 32'h1);
    #1 check(conv_irq, 1'b0);
    rd_chk(ADDR_STATUS, 32'h0);
  endtask

  task automatic t_clocks;
    logic [2:0] sel [6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
    logic [9:0] val [6] = '{10'h3FF, 10'h000, 10'h155, 10'h201,
                            10'h1FE, 10'h0C3};
    int c, p;
    wr(ADDR_ENABLE, 32'h0);
    for (int k = 0; k < 6; k++)
    begin
      p = 2 << k;
      vin <= val[k];
      wr(ADDR_CONTROL, ctl(sel[k], k[0], 1'b1));
      wait_done(cyc_cnt, c);
      check(c >= 10 * p && c <= 11 * p + 12, 1'b1);
      rd_chk(ADDR_RESULT, res(val[k], k[0]));
      rd_chk(ADDR_CONTROL, ctl(sel[k], k[0], 1'b0));
      wr(ADDR_CLEAR, 32'h1);
    end
  endtask

  task automatic t_sleep(input logic gie, input logic [2:0] s);
    int n;
    n = 0;
    gie_cmd <= gie;
    vin <= 10'h17C;
    wr(ADDR_ENABLE, 32'h1);
    sleep_cmd <= 1'b1;
    @(posedge ref_clk);
    sleep_cmd <= 1'b0;
    wr(ADDR_CONTROL, ctl(s, gie, 1'b1));
    do
    begin
      @(posedge ref_clk);
      #1 n++;
    end while (wake_req !== 1'b1 && n < 1000);
    check({wake_req, conv_irq}, 2'b11);
    check(n > 10 * 34 && n < 12 * 34 + 20, 1'b1);
    @(posedge ref_clk);
    #1 check({exec_next_instr, vector_isr, resume_inline}, 3'b100);
    @(posedge ref_clk);
    #1 check({vector_isr, resume_inline}, {gie, ~gie});
    rd_chk(ADDR_RESULT, res(10'h17C, gie));
    wr(ADDR_CLEAR, 32'h1);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_irq_busy();
    t_clocks();
    t_sleep(1'b1, 3'h3);
    t_sleep(1'b0, 3'h7);
    stop_test();
  end

  initial
  begin
    #2_000_000;
    err_count++;
    stop_test();
  end
endmodule

`default_nettype wire
